// ---- iop_ports.sv ----
// Port logic: 3-line group port, 8-line port, 3-line input port with comparators.
// Assumes pads resolve the wire from out/oe_n, analog comparators outside give
// digital results, and a CPU register port with read data one cycle later.
// How it works
// - Three-line port direction set for all lines by one bit.
// - Each of the eight lines has its own direction bit.
// - One bit chooses push-pull or open-drain for all eight output lines.
// - Input lines are digital or analog per software, analog feeds comparators.
// - Input lines source the external interrupt requests and the timer input.
// - Comparators A and B compare against the shared reference line.
// - Comparator B output raises a request on either edge.
// - Comparator A output raises a request only on falling edge.
// - Comparator outputs feed requests, input data, and timer via line A.
// - Comparators off frees reference line as digital input and request.
// - Comparators are powered down while in stop mode.
// - Keeper holds undriven bidirectional inputs; input-only lines excluded.
// - Keepers enabled by default unless the build option disables them.
// - Fourth request detects rising edges, others falling; comparator B request takes either edge.
`timescale 1ns/10ps
`default_nettype none
`include "iop_regs.svh"
module iop_ports
  import iop_pkg::*;
#(
  parameter bit KEEPER_DISABLE = 1'b0
)
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Power state
  input  wire logic       stop_mode,
  // Three-line bidirectional pins
  input  wire logic [2:0] tri_line_in,
  output logic [2:0]      tri_line_out,
  output logic [2:0]      tri_line_oe_n,
  // Eight-line bidirectional pins
  input  wire logic [7:0] octal_in,
  output logic [7:0]      octal_out,
  output logic [7:0]      octal_oe_n,
  // Input-only lines and comparator results
  input  wire logic [2:0] input_only_lines,
  input  wire logic       cmp_a_result,
  input  wire logic       cmp_b_result,
  output logic            cmp_enable,
  // Requests and timer
  output logic [3:0]      external_int_requests,
  output logic            timer_ext_in,
  output logic            irq
);
  iop_byte_t tri_out_reg;
  iop_byte_t tri_cfg;
  iop_byte_t oct_out_reg;
  iop_byte_t oct_dir;
  iop_byte_t oct_cfg;
  iop_byte_t in_cfg;
  iop_byte_t int_mask;
  logic [3:0] int_stat;
  logic [2:0] tri_sync;
  logic [7:0] oct_sync;
  logic [2:0] in_level;
  logic [2:0] in_rise;
  logic [2:0] in_fall;
  logic       ca_level;
  logic       ca_rise;
  logic       ca_fall;
  logic       cb_level;
  logic       cb_rise;
  logic       cb_fall;
  logic [2:0] tri_keep;
  logic [7:0] oct_keep;
  logic       analog;
  logic       keeper_on;
  logic [2:0] in_data;
  logic [3:0] next_events;
  logic [3:0] clr_bits;
  logic [7:0] next_rdata;
  // Comparator warm-up and per-line octal drive
  logic [2:0] cmp_warm;
  logic       cmp_live;
  wire  logic [7:0] next_oct_out;
  wire  logic [7:0] next_oct_oe_n;

  // Synchronise input-only lines and comparator results
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_in
      iop_sync u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (input_only_lines[gi]),
        .level    (in_level[gi]),
        .rise     (in_rise[gi]),
        .fall     (in_fall[gi])
      );
    end
  endgenerate

  iop_sync u_cmp_a (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (cmp_a_result),
    .level    (ca_level),
    .rise     (ca_rise),
    .fall     (ca_fall)
  );

  iop_sync u_cmp_b (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (cmp_b_result),
    .level    (cb_level),
    .rise     (cb_rise),
    .fall     (cb_fall)
  );

  // Bidirectional pin inputs go through two flops too
  logic [2:0] tri_meta;
  logic [7:0] oct_meta;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tri_meta <= 3'h0;
      tri_sync <= 3'h0;
      oct_meta <= 8'h00;
      oct_sync <= 8'h00;
    end
    else
    begin
      tri_meta <= tri_line_in;
      tri_sync <= tri_meta;
      oct_meta <= octal_in;
      oct_sync <= oct_meta;
    end
  end

  assign analog    = in_cfg[`IOP_BIT_IN_ANALOG];
  assign keeper_on = ~KEEPER_DISABLE & ~tri_cfg[`IOP_BIT_KEEPER_OFF];

  // Analog mode swaps lines A and B for comparator results
  assign in_data = analog ? {in_level[2], cb_level, ca_level} : in_level;

  // Comparator edges count only once a powered result has crossed the
  // synchroniser; an unpowered or waking comparator gives garbage levels
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cmp_warm <= 3'h0;
    else
      cmp_warm <= cmp_enable ? {cmp_warm[1:0], 1'b1} : 3'h0;
  end

  assign cmp_live = cmp_enable & cmp_warm[2];

  // Events: 0 line A / cmp A fall, 1 reference fall, 2 line B / cmp B, 3 rise
  // Comparator edges wait for cmp_live so a waking comparator sets nothing
  always_comb
  begin
    next_events    = 4'h0;
    next_events[0] = analog ? (cmp_live & ca_fall) : in_fall[0];
    next_events[1] = analog ? 1'b0 : in_fall[2];
    next_events[2] = analog ? (cmp_live & (cb_rise | cb_fall)) : in_fall[1];
    next_events[3] = analog ? 1'b0 : in_rise[1];
  end

  // Write-one-to-clear strobe for the status bits
  assign clr_bits = (reg_wr && reg_addr == `IOP_OFF_INT_STAT) ? reg_wdata[3:0] : 4'h0;

  // Sticky status, set beats write-one-to-clear
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      int_stat <= 4'h0;
    else
      int_stat <= (int_stat & ~clr_bits) | next_events;
  end

  // Request pulses follow the event vector one edge later
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      external_int_requests <= 4'h0;
    else
      external_int_requests <= next_events;
  end

  // Level interrupt from unmasked sticky bits; a mask write alone can raise it
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(int_stat & int_mask[3:0]);
  end

  // Timer input from line A, or from comparator A in analog mode
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      timer_ext_in <= 1'b0;
    else
      timer_ext_in <= in_data[0];
  end

  // Comparator power follows analog mode and drops on the next edge in stop mode
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cmp_enable <= 1'b0;
    else
      cmp_enable <= analog & ~stop_mode;
  end

  // Software-written configuration
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tri_out_reg <= 8'h00;
      tri_cfg     <= `IOP_RST_TRI_CFG;
      oct_out_reg <= 8'h00;
      oct_dir     <= `IOP_RST_OCT_DIR;
      oct_cfg     <= `IOP_RST_OCT_CFG;
      in_cfg      <= `IOP_RST_IN_CFG;
      int_mask    <= `IOP_RST_INT_MASK;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `IOP_OFF_TRI_OUT:  tri_out_reg <= reg_wdata;
        `IOP_OFF_TRI_CFG:  tri_cfg     <= reg_wdata;
        `IOP_OFF_OCT_OUT:  oct_out_reg <= reg_wdata;
        `IOP_OFF_OCT_DIR:  oct_dir     <= reg_wdata;
        `IOP_OFF_OCT_CFG:  oct_cfg     <= reg_wdata;
        `IOP_OFF_IN_CFG:   in_cfg      <= reg_wdata;
        `IOP_OFF_INT_MASK: int_mask    <= reg_wdata;
        default:           ;
      endcase
    end
  end

  // Keepers follow the last seen level of undriven inputs
  // Limitation: a keeper drives like an output, so it wins over a far driver
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tri_keep <= 3'h0;
      oct_keep <= 8'h00;
    end
    else
    begin
      tri_keep <= tri_sync;
      oct_keep <= oct_sync;
    end
  end

  // Three-line pin drive; oe_n low means driving
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tri_line_out  <= 3'h0;
      tri_line_oe_n <= 3'h7;
    end
    else if (tri_cfg[`IOP_BIT_TRI_DIR_OUT])
    begin
      tri_line_out  <= tri_out_reg[2:0];
      tri_line_oe_n <= 3'h0;
    end
    else
    begin
      // Released group: keeper drives back the last seen level
      tri_line_out  <= tri_keep;
      tri_line_oe_n <= keeper_on ? 3'h0 : 3'h7;
    end
  end

  // Per-line drive choice for the eight-line port; direction bit 1 is input
  // Open-drain drives only the low level and floats the high one
  genvar go;
  generate
    for (go = 0; go < 8; go = go + 1)
    begin : g_oct
      assign next_oct_out[go]  = oct_dir[go] ? oct_keep[go] : oct_out_reg[go];
      assign next_oct_oe_n[go] = oct_dir[go] ? ~keeper_on
                                             : (oct_cfg[`IOP_BIT_OCT_OPEN_DR] & oct_out_reg[go]);
    end
  endgenerate

  // Eight-line pins registered as a whole so every output leaves a flop
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      octal_out  <= 8'h00;
      octal_oe_n <= 8'hFF;
    end
    else
    begin
      octal_out  <= next_oct_out;
      octal_oe_n <= next_oct_oe_n;
    end
  end

  // Read mux; unmapped reads return zero
  always_comb
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      `IOP_OFF_TRI_OUT:  next_rdata = tri_out_reg;
      `IOP_OFF_TRI_CFG:  next_rdata = tri_cfg;
      `IOP_OFF_OCT_OUT:  next_rdata = oct_out_reg;
      `IOP_OFF_OCT_DIR:  next_rdata = oct_dir;
      `IOP_OFF_OCT_CFG:  next_rdata = oct_cfg;
      `IOP_OFF_IN_CFG:   next_rdata = in_cfg;
      `IOP_OFF_IN_DATA:  next_rdata = {5'h00, in_data};
      `IOP_OFF_INT_STAT: next_rdata = {4'h0, int_stat};
      `IOP_OFF_INT_MASK: next_rdata = int_mask;
      `IOP_OFF_TRI_IN:   next_rdata = {5'h00, tri_sync};
      `IOP_OFF_OCT_IN:   next_rdata = oct_sync;
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
  end
endmodule
`default_nettype wire

// ---- iop_regs.svh ----
// Constants for the port block: register offsets, field positions, reset values.
// Assumes a byte-wide register port addressed by a 4-bit offset.
`ifndef IOP_REGS_SVH
`define IOP_REGS_SVH

`define IOP_OFF_TRI_OUT    4'h0
`define IOP_OFF_TRI_CFG    4'h1
`define IOP_OFF_OCT_OUT    4'h2
`define IOP_OFF_OCT_DIR    4'h3
`define IOP_OFF_OCT_CFG    4'h4
`define IOP_OFF_IN_CFG     4'h5
`define IOP_OFF_IN_DATA    4'h6
`define IOP_OFF_INT_STAT   4'h7
`define IOP_OFF_INT_MASK   4'h8
`define IOP_OFF_TRI_IN     4'h9
`define IOP_OFF_OCT_IN     4'hA

`define IOP_BIT_TRI_DIR_OUT   0
`define IOP_BIT_OCT_OPEN_DR   0
`define IOP_BIT_IN_ANALOG     0
`define IOP_BIT_KEEPER_OFF    1

`define IOP_RST_TRI_CFG   8'h00
`define IOP_RST_OCT_DIR   8'hFF
`define IOP_RST_OCT_CFG   8'h00
`define IOP_RST_IN_CFG    8'h00
`define IOP_RST_INT_MASK  8'h00

`endif

// ---- iop_pkg.sv ----
// Types shared by the port block.
// Assumes nothing beyond the constants header.
package iop_pkg;
  typedef logic [7:0] iop_byte_t;
  typedef logic [3:0] iop_addr_t;
endpackage

// ---- iop_sync.sv ----
// Two-stage synchroniser with one-cycle rise and fall pulses.
// Assumes input asynchronous to sys_clk; first stage feeds only the second.
`timescale 1ns/10ps
`default_nettype none
module iop_sync
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Raw level in
  input  wire logic async_in,
  // Synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic       meta;
  logic       hold;
  logic [2:0] arm;

  // Two flops, then a third stage for edge compare
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta  <= 1'b0;
      level <= 1'b0;
      hold  <= 1'b0;
    end
    else
    begin
      meta  <= async_in;
      level <= meta;
      hold  <= level;
    end
  end

  // Edges stay quiet until every stage holds a real sample; a line idling
  // high would otherwise look like a rise right after reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      arm <= 3'h0;
    else
      arm <= {arm[1:0], 1'b1};
  end

  // Edges look only at synchronised stages
  assign rise = arm[2] & level & ~hold;
  assign fall = arm[2] & ~level & hold;
endmodule
`default_nettype wire

// ---- iop_checker.sv ----
// Port-level assertions for the port block, bound into iop_ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module iop_checker
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Register port and mode
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       stop_mode,
  // Pins and results
  input wire logic [2:0] tri_line_oe_n,
  input wire logic [2:0] input_only_lines,
  input wire logic       cmp_enable,
  input wire logic [3:0] external_int_requests,
  input wire logic       irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Read data only in the cycle after a read
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  // Group direction: all lines driven or none
  a_tri_group: assert property (tri_line_oe_n == 3'h0 || tri_line_oe_n == 3'h7)
    else $error("three-line port split direction");
  // Comparators drop on the edge after stop mode
  a_cmp_stop: assert property (stop_mode |=> !cmp_enable)
    else $error("comparators powered in stop mode");
  // Each edge gives a single pulse
  a_one_shot: assert property ((external_int_requests & $past(external_int_requests)) == 4'h0)
    else $error("request longer than one cycle");
  // Rising request follows line B rise three edges on
  a_req_rise: assert property (external_int_requests[3] |->
    $past(input_only_lines[1], 3) && !$past(input_only_lines[1], 4))
    else $error("rising request without line rise");
  // Reference request only with comparators off
  a_ref_digital: assert property (external_int_requests[1] |-> !cmp_enable)
    else $error("reference request in analog mode");
  // Interrupt rises only from an event or a write
  a_irq_rise: assert property ($rose(irq) |->
    $past(|external_int_requests) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt rose without cause");
  // Interrupt falls only after a clear or mask write
  a_irq_fall: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt fell without write");
endmodule
bind iop_ports iop_checker u_chk (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_rdata, .stop_mode,
  .tri_line_oe_n, .input_only_lines, .cmp_enable, .external_int_requests, .irq);
`default_nettype wire

// ---- iop_pins.sv ----
// Pin and comparator model facing the port block.
// Assumes line voltages as bytes from the bench; bit 7 is the digital level.
`timescale 1ns/10ps
`default_nettype none
module iop_pins
(
  // Clock
  input  wire logic       sys_clk,
  // Device side
  input  wire logic [2:0] tri_line_out,
  input  wire logic [2:0] tri_line_oe_n,
  input  wire logic [7:0] octal_out,
  input  wire logic [7:0] octal_oe_n,
  input  wire logic       cmp_enable,
  // Bench side
  input  wire logic       tri_en,
  input  wire logic [2:0] tri_val,
  input  wire logic [7:0] va,
  input  wire logic [7:0] vb,
  input  wire logic [7:0] vr,
  // Resolved levels
  output logic [2:0]      tri_line_in,
  output logic [7:0]      octal_in,
  output logic [2:0]      input_only_lines,
  output logic            cmp_a_result,
  output logic            cmp_b_result
);
  logic flip = 1'b0;
  // Floating nodes toggle so a stale level never looks valid
  always_ff @(posedge sys_clk)
    flip <= ~flip;
  // Device drive wins; octal lines have a pull-up for open-drain use
  assign tri_line_in = (~tri_line_oe_n & tri_line_out) | (tri_line_oe_n & (tri_en ? tri_val : {3{flip}}));
  assign octal_in = (~octal_oe_n & octal_out) | octal_oe_n;
  assign input_only_lines = {vr[7], vb[7], va[7]};
  // Shared reference; unpowered outputs are garbage
  assign cmp_a_result = cmp_enable ? (va > vr) : flip;
  assign cmp_b_result = cmp_enable ? (vb > vr) : flip;
endmodule
`default_nettype wire

// ---- iop_ports_tb.sv ----
// Self-checking bench for the port block over its register port.
// Assumes iop_pins for the far side and iop_checker bound in.
`timescale 1ns/10ps
`default_nettype none
`include "iop_regs.svh"
module iop_ports_tb;
  import iop_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       stop_mode = 1'b0;
  logic       tri_en = 1'b0;
  logic [2:0] tri_val = 3'h0;
  iop_addr_t  reg_addr = 4'h0;
  iop_byte_t  reg_wdata = 8'h00;
  iop_byte_t  va = 8'hFF, vb = 8'hFF, vr = 8'hFF;
  iop_byte_t  reg_rdata, octal_out, octal_oe_n, octal_in;
  logic [2:0] tri_line_in, tri_line_out, tri_line_oe_n, input_only_lines;
  logic [3:0] external_int_requests;
  logic       irq, cmp_enable, timer_ext_in, cmp_a_result, cmp_b_result;
  int         error_cnt = 0;
  int         comparisons = 0;
  iop_ports u_dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .stop_mode,
    .tri_line_in, .tri_line_out, .tri_line_oe_n, .octal_in, .octal_out, .octal_oe_n, .input_only_lines,
    .cmp_a_result, .cmp_b_result, .cmp_enable, .external_int_requests, .timer_ext_in, .irq);
  iop_pins u_pins (.sys_clk, .tri_line_out, .tri_line_oe_n, .octal_out, .octal_oe_n, .cmp_enable,
    .tri_en, .tri_val, .va, .vb, .vr, .tri_line_in, .octal_in, .input_only_lines, .cmp_a_result,
    .cmp_b_result);
  // Clock
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input iop_byte_t s, input iop_byte_t e);
    comparisons++;
    if (s !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Strobe drops after its edge, one idle cycle keeps drivers single
  task automatic wr(input iop_addr_t a, input iop_byte_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input iop_addr_t a, input iop_byte_t e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", reg_rdata, e);
    @(posedge sys_clk);
  endtask
  // Sync plus event latency is four edges
  task automatic settle;
    repeat (5) @(posedge sys_clk);
  endtask
  // Move lines, expect request pulse, status and interrupt, then clear
  task automatic ev(input logic [23:0] v, input iop_byte_t s, input logic i);
    {va, vb, vr} <= v;
    repeat (3) @(posedge sys_clk);
    #1 chk("req", external_int_requests, s);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq", irq, i);
    rd(`IOP_OFF_INT_STAT, s);
    wr(`IOP_OFF_INT_STAT, 8'hFF);
    #1 chk("irq", irq, 1'b0);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(`IOP_OFF_TRI_CFG, `IOP_RST_TRI_CFG);
    rd(`IOP_OFF_OCT_DIR, `IOP_RST_OCT_DIR);
    rd(`IOP_OFF_OCT_CFG, `IOP_RST_OCT_CFG);
    rd(`IOP_OFF_INT_MASK, `IOP_RST_INT_MASK);
    rd(4'hF, 8'h00);
    wr(`IOP_OFF_TRI_CFG, 8'h01);
    wr(`IOP_OFF_TRI_OUT, 8'h05);
    #1 chk("tri_oe_n", tri_line_oe_n, 3'h0);
    chk("tri_out", tri_line_out, 3'h5);
    tri_en <= 1'b1;
    tri_val <= 3'h6;
    wr(`IOP_OFF_TRI_CFG, 8'h02);
    settle();
    rd(`IOP_OFF_TRI_IN, 8'h06);
    wr(`IOP_OFF_TRI_CFG, 8'h00);
    settle();
    tri_en <= 1'b0;
    settle();
    chk("keeper", {tri_line_oe_n, tri_line_out}, 6'h06);
    wr(`IOP_OFF_OCT_DIR, 8'h0F);
    wr(`IOP_OFF_OCT_OUT, 8'hA5);
    #1 chk("oct_oe_hi", octal_oe_n[7:4], 4'h0);
    wr(`IOP_OFF_OCT_DIR, 8'h00);
    wr(`IOP_OFF_OCT_CFG, 8'h01);
    #1 chk("oct_od", octal_oe_n, 8'hA5);
    chk("oct_low", octal_out & ~octal_oe_n, 8'h00);
    settle();
    rd(`IOP_OFF_OCT_IN, 8'hA5);
    wr(`IOP_OFF_INT_MASK, 8'h0F);
    ev(24'h00FFFF, 8'h01, 1'b1);
    chk("timer", timer_ext_in, 1'b0);
    rd(`IOP_OFF_IN_DATA, 8'h06);
    ev(24'h00FF00, 8'h02, 1'b1);
    ev(24'h000000, 8'h04, 1'b1);
    ev(24'h00FF00, 8'h08, 1'b1);
    wr(`IOP_OFF_INT_MASK, 8'h00);
    ev(24'h000000, 8'h04, 1'b0);
    wr(`IOP_OFF_INT_MASK, 8'h0F);
    {va, vb, vr} <= 24'hC04080;
    wr(`IOP_OFF_IN_CFG, 8'h01);
    settle();
    wr(`IOP_OFF_INT_STAT, 8'hFF);
    chk("cmp_en", cmp_enable, 1'b1);
    ev(24'hC0C080, 8'h04, 1'b1);
    ev(24'hC04080, 8'h04, 1'b1);
    ev(24'h404080, 8'h01, 1'b1);
    ev(24'hC04080, 8'h00, 1'b0);
    ev(24'hC04000, 8'h04, 1'b1);
    chk("timer", timer_ext_in, 1'b1);
    rd(`IOP_OFF_IN_DATA, 8'h03);
    stop_mode <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("cmp_en", cmp_enable, 1'b0);
    stop_mode <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rd(`IOP_OFF_IN_CFG, `IOP_RST_IN_CFG);
    end_of_test();
  end
  // Watchdog well past the roughly 175 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
